/* File: common/isrf_regs.vh */
`ifndef ISRF_REGS_VH
`define ISRF_REGS_VH
// header word 0: bit 15 forced high, others undefined (driven zero)
`define ISRF_HDR0_LO        8'h00
`define ISRF_HDR0_HI        8'h80
`define ISRF_HDR_BYTES      16'h0004
// general block: sample number (2), error code (1), status (1)
`define ISRF_GEN_BYTES      16'h0004
// analog out 8x2, analog in 8x2, out/in state 2x4, pulse 4, two user vars 2x4
`define ISRF_IO_BYTES       16'h0034
`define ISRF_EXT_BYTES      16'h0008
// general status bit positions
`define ISRF_ST_RUN         7
`define ISRF_ST_WAIT_IN     2
`define ISRF_ST_TRACE       1
`define ISRF_ST_ECHO        0
// byte index milestones inside the record
`define ISRF_IDX_HDR0       7'h00
`define ISRF_IDX_HDR1       7'h01
`define ISRF_IDX_LEN_LO     7'h02
`define ISRF_IDX_LEN_HI     7'h03
`define ISRF_IDX_SAMPLE     7'h04
`define ISRF_IDX_ERR        7'h06
`define ISRF_IDX_STAT       7'h07
`define ISRF_IDX_AOUT       7'h08
`define ISRF_IDX_AIN        7'h18
`define ISRF_IDX_DOUT       7'h28
`define ISRF_IDX_DIN        7'h2C
`define ISRF_IDX_PULSE      7'h30
`define ISRF_IDX_UVA        7'h34
`define ISRF_IDX_UVB        7'h38
`define ISRF_IDX_EXT        7'h3C
`define ISRF_IDX_END_STD    7'h3C
`define ISRF_IDX_END_EXT    7'h44
`endif

/* File: core/isrf_framer.v */
// Operation
// - extended option appends four 16-bit I/O words
// - analog input signedness follows range, low first (analog_input_range_select is unused here; words are carried raw)
// - header word 0 has bit 15 set
// - header bytes 2,3 hold total length
// - status byte: run, wait input, trace, echo
// - general block directly follows the header
// - two user variables in every record
// - outputs grouped in banks of eight
// - four header bytes precede each record
// - sample 16-bit, error 8-bit, status 8-bit
`timescale 1ns/100ps
`default_nettype none
`include "isrf_regs.vh"
module isrf_framer #(
	parameter N_AOUT = 8,
	parameter N_AIN  = 8
) (
	// clock and reset
	input  wire         clock,
	input  wire         nrst,
	input  wire         clk_en,
	// requests (same clock domain)
	input  wire         single_snapshot_request,
	input  wire         periodic_snapshot_request,
	input  wire         snapshot_tick,
	input  wire         ext_io_fitted,
	// snapshot sources
	input  wire [7:0]   error_code,
	input  wire         prog_running,
	input  wire         wait_input,
	input  wire         trace_on,
	input  wire         echo_on,
	input  wire [127:0] analog_out_counts,
	input  wire [127:0] analog_in_counts,
	input  wire [7:0]   analog_input_range_select,
	input  wire [23:0]  dig_out,
	input  wire [23:0]  dig_in,
	input  wire [23:0]  ext_dig_out,
	input  wire [23:0]  ext_dig_in,
	input  wire [31:0]  pulse_count,
	input  wire [31:0]  user_variable_a,
	input  wire [31:0]  user_variable_b,
	// byte stream out
	output reg  [7:0]   rec_data_ff,
	output reg          rec_valid_ff,
	output reg          rec_last_ff,
	input  wire         rec_ready,
	// status
	output reg          busy_ff,
	output reg  [15:0]  sample_num_ff
);
	reg  [6:0]   idx_ff;
	reg  [6:0]   end_ff;
	reg  [15:0]  len_ff;
	reg  [7:0]   stat_ff;
	reg  [7:0]   err_ff;
	reg  [127:0] aout_ff;
	reg  [127:0] ain_ff;
	reg  [23:0]  dout_ff;
	reg  [23:0]  din_ff;
	reg  [23:0]  xout_ff;
	reg  [23:0]  xin_ff;
	reg  [31:0]  pulse_ff;
	reg  [31:0]  uva_ff;
	reg  [31:0]  uvb_ff;
	// two-entry skid buffer: the rec_* outputs are its head entry
	reg  [8:0]   buf1_ff;
	reg  [1:0]   cnt_ff;
	reg  [7:0]   byte_c;
	reg  [6:0]   off_c;
	reg  [15:0]  word_c;
	wire         start;
	wire         push;
	wire         pop;
	wire         last_c;
	wire [31:0]  dout_w;
	wire [31:0]  din_w;
	wire [15:0]  ain_w [0:N_AIN-1];

	assign start = clk_en && !busy_ff &&
		(single_snapshot_request || (periodic_snapshot_request && snapshot_tick));
	assign push  = clk_en && busy_ff && (cnt_ff != 2'h2);
	assign pop   = clk_en && rec_valid_ff && rec_ready;
	assign last_c = (idx_ff + 7'h01) == end_ff;
	// bank 2 sits in the low byte of its word; the upper byte is padding, never unknown
	assign dout_w = {8'h00, dout_ff};
	assign din_w  = {8'h00, din_ff};

	// the field is carried raw; signed ranges already arrive in two's complement
	genvar g;
	generate
		for (g = 0; g < N_AIN; g = g + 1) begin : g_ain
			assign ain_w[g] = ain_ff[g*16 +: 16];
		end
	endgenerate

	always @* begin
		byte_c = 8'h00;
		off_c  = 7'h00;
		word_c = 16'h0000;
		if (idx_ff == `ISRF_IDX_HDR0)
			byte_c = `ISRF_HDR0_LO;
		else if (idx_ff == `ISRF_IDX_HDR1)
			byte_c = `ISRF_HDR0_HI;
		else if (idx_ff == `ISRF_IDX_LEN_LO)
			byte_c = len_ff[7:0];
		else if (idx_ff == `ISRF_IDX_LEN_HI)
			byte_c = len_ff[15:8];
		else if (idx_ff < `ISRF_IDX_ERR)
			byte_c = idx_ff[0] ? sample_num_ff[15:8] : sample_num_ff[7:0];
		else if (idx_ff == `ISRF_IDX_ERR)
			byte_c = err_ff;
		else if (idx_ff == `ISRF_IDX_STAT)
			byte_c = stat_ff;
		else if (idx_ff < `ISRF_IDX_AIN) begin
			off_c  = idx_ff - `ISRF_IDX_AOUT;
			byte_c = aout_ff[off_c*8 +: 8];
		end else if (idx_ff < `ISRF_IDX_DOUT) begin
			off_c  = idx_ff - `ISRF_IDX_AIN;
			word_c = ain_w[off_c[3:1]];
			byte_c = off_c[0] ? word_c[15:8] : word_c[7:0];
		end else if (idx_ff < `ISRF_IDX_DIN) begin
			off_c  = idx_ff - `ISRF_IDX_DOUT;
			byte_c = dout_w[off_c[1:0]*8 +: 8];
		end else if (idx_ff < `ISRF_IDX_PULSE) begin
			off_c  = idx_ff - `ISRF_IDX_DIN;
			byte_c = din_w[off_c[1:0]*8 +: 8];
		end else if (idx_ff < `ISRF_IDX_UVA) begin
			off_c  = idx_ff - `ISRF_IDX_PULSE;
			byte_c = pulse_ff[off_c[1:0]*8 +: 8];
		end else if (idx_ff < `ISRF_IDX_UVB) begin
			off_c  = idx_ff - `ISRF_IDX_UVA;
			byte_c = uva_ff[off_c[1:0]*8 +: 8];
		end else if (idx_ff < `ISRF_IDX_EXT) begin
			off_c  = idx_ff - `ISRF_IDX_UVB;
			byte_c = uvb_ff[off_c[1:0]*8 +: 8];
		end else begin
			// ext order: out 24-39, out 40-47, in 24-39, in 40-47
			off_c = idx_ff - `ISRF_IDX_EXT;
			case (off_c[2:0])
				3'h0: byte_c = xout_ff[7:0];
				3'h1: byte_c = xout_ff[15:8];
				3'h2: byte_c = xout_ff[23:16];
				3'h3: byte_c = 8'h00;
				3'h4: byte_c = xin_ff[7:0];
				3'h5: byte_c = xin_ff[15:8];
				3'h6: byte_c = xin_ff[23:16];
				default: byte_c = 8'h00;
			endcase
		end
	end

	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			idx_ff        <= 7'h00;
			end_ff        <= 7'h00;
			len_ff        <= 16'h0000;
			busy_ff       <= 1'b0;
			sample_num_ff <= 16'h0000;
			stat_ff       <= 8'h00;
			err_ff        <= 8'h00;
			aout_ff       <= 128'h0;
			ain_ff        <= 128'h0;
			dout_ff       <= 24'h0;
			din_ff        <= 24'h0;
			xout_ff       <= 24'h0;
			xin_ff        <= 24'h0;
			pulse_ff      <= 32'h0;
			uva_ff        <= 32'h0;
			uvb_ff        <= 32'h0;
		end else if (start) begin
			// capture the whole snapshot so the record is self-consistent
			busy_ff       <= 1'b1;
			idx_ff        <= 7'h00;
			sample_num_ff <= sample_num_ff + 16'h0001;
			end_ff        <= ext_io_fitted ? `ISRF_IDX_END_EXT : `ISRF_IDX_END_STD;
			len_ff        <= `ISRF_HDR_BYTES + `ISRF_GEN_BYTES + `ISRF_IO_BYTES +
				(ext_io_fitted ? `ISRF_EXT_BYTES : 16'h0000);
			stat_ff       <= {prog_running, 4'h0, wait_input, trace_on, echo_on};
			err_ff        <= error_code;
			aout_ff       <= analog_out_counts;
			ain_ff        <= analog_in_counts;
			dout_ff       <= dig_out;
			din_ff        <= dig_in;
			xout_ff       <= ext_dig_out;
			xin_ff        <= ext_dig_in;
			pulse_ff      <= pulse_count;
			uva_ff        <= user_variable_a;
			uvb_ff        <= user_variable_b;
		end else if (push) begin
			idx_ff <= idx_ff + 7'h01;
			if (last_c)
				busy_ff <= 1'b0;
		end
	end

	// the head entry is the output register itself, so the stream leaves straight from flops
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			buf1_ff      <= 9'h000;
			cnt_ff       <= 2'h0;
			rec_data_ff  <= 8'h00;
			rec_valid_ff <= 1'b0;
			rec_last_ff  <= 1'b0;
		end else if (clk_en) begin
			case ({push, pop})
				2'b10: begin
					if (cnt_ff == 2'h0) begin
						rec_data_ff <= byte_c;
						rec_last_ff <= last_c;
					end else
						buf1_ff <= {last_c, byte_c};
					rec_valid_ff <= 1'b1;
					cnt_ff       <= cnt_ff + 2'h1;
				end
				2'b01: begin
					rec_data_ff  <= buf1_ff[7:0];
					rec_last_ff  <= buf1_ff[8];
					rec_valid_ff <= cnt_ff == 2'h2;
					cnt_ff       <= cnt_ff - 2'h1;
				end
				2'b11: begin
					if (cnt_ff == 2'h1) begin
						rec_data_ff <= byte_c;
						rec_last_ff <= last_c;
					end else begin
						rec_data_ff <= buf1_ff[7:0];
						rec_last_ff <= buf1_ff[8];
						buf1_ff     <= {last_c, byte_c};
					end
				end
				default: cnt_ff <= cnt_ff;
			endcase
		end
	end
endmodule
`default_nettype wire

/* File: dv/isrf_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module isrf_host_model (
	// stream
	input  wire logic       clock,
	input  wire logic       nrst,
	input  wire logic [7:0] rec_data_ff,
	input  wire logic       rec_valid_ff,
	output logic            rec_ready,
	// control
	input  wire logic       stall,
	input  wire logic       clear
);
	logic [7:0] mem [0:127];
	int         n_rx;
	logic       tgl_ff;
	// a stalling host drops ready on every other cycle
	assign rec_ready = !stall | tgl_ff;
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tgl_ff <= 1'b0;
			n_rx <= 0;
		end else begin
			tgl_ff <= !tgl_ff;
			if (clear)
				n_rx <= 0;
			else if (rec_valid_ff && rec_ready) begin
				mem[n_rx[6:0]] <= rec_data_ff;
				n_rx <= n_rx + 1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: dv/isrf_framer_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module isrf_framer_monitor (
	// clock and reset
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        clk_en,
	// requests
	input wire logic        single_snapshot_request,
	input wire logic        periodic_snapshot_request,
	input wire logic        snapshot_tick,
	input wire logic        ext_io_fitted,
	// status sources
	input wire logic        prog_running,
	input wire logic        wait_input,
	input wire logic        trace_on,
	input wire logic        echo_on,
	// byte stream and status
	input wire logic [7:0]  rec_data_ff,
	input wire logic        rec_valid_ff,
	input wire logic        rec_last_ff,
	input wire logic        rec_ready,
	input wire logic        busy_ff,
	input wire logic [15:0] sample_num_ff
);
	logic [6:0] idx_ff;
	wire        v = rec_valid_ff;
	always_ff @(posedge clock or negedge nrst)
		if (!nrst) idx_ff <= 7'h00;
		else if (clk_en && v && rec_ready) idx_ff <= rec_last_ff ? 7'h00 : idx_ff + 7'h01;
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	sequence s_start;
		clk_en && !busy_ff && (single_snapshot_request || periodic_snapshot_request && snapshot_tick);
	endsequence
	sequence s_step;
		sample_num_ff == $past(sample_num_ff) + 16'h0001;
	endsequence
	sample_step_a: assert property (s_start |=> s_step) else $error("sample step");
	sample_hold_a: assert property (busy_ff |=> $stable(sample_num_ff)) else $error("sample hold");
	freeze_hold_a: assert property (!clk_en |=> $stable(sample_num_ff) && $stable(busy_ff) && $stable(v))
		else $error("freeze");
	byte_hold_a: assert property (v && !rec_ready |=> v && $stable(rec_data_ff)) else $error("hold");
	hdr_marker_a: assert property (v && idx_ff == 7'h01 |-> rec_data_ff == 8'h80) else $error("hdr");
	len_low_a: assert property (v && idx_ff == 7'h02 |-> rec_data_ff == (ext_io_fitted ? 8'h44 : 8'h3C))
		else $error("len lo");
	len_high_a: assert property (v && idx_ff == 7'h03 |-> rec_data_ff == 8'h00) else $error("len hi");
	sample_low_a: assert property (v && idx_ff == 7'h04 |-> rec_data_ff == sample_num_ff[7:0])
		else $error("sample lo");
	sample_high_a: assert property (v && idx_ff == 7'h05 |-> rec_data_ff == sample_num_ff[15:8])
		else $error("sample hi");
	status_byte_a: assert property (v && idx_ff == 7'h07 |->
		rec_data_ff == {prog_running, 4'h0, wait_input, trace_on, echo_on}) else $error("status");
	record_end_a: assert property (v |-> rec_last_ff == (idx_ff == (ext_io_fitted ? 7'h43 : 7'h3B)))
		else $error("last");
endmodule
`default_nettype wire

/* File: dv/tb_isrf_framer.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_mismatch++; \
	$display("ERROR %s exp %h got %h", n, e, s); end end
module tb_isrf_framer;
	logic clock = 0, nrst = 0, clk_en = 1, single_snapshot_request = 0, periodic_snapshot_request = 0;
	logic snapshot_tick = 0, ext_io_fitted = 0, prog_running = 0, wait_input = 0, trace_on = 0, echo_on = 0;
	logic [7:0]   error_code = 0, analog_input_range_select = 0, rec_data_ff;
	logic [127:0] analog_out_counts = 0, analog_in_counts = 0;
	logic [23:0]  dig_out = 0, dig_in = 0, ext_dig_out = 0, ext_dig_in = 0;
	logic [31:0]  pulse_count = 0, user_variable_a = 0, user_variable_b = 0;
	logic         rec_valid_ff, rec_last_ff, rec_ready, busy_ff, stall = 0, clear = 0;
	logic [15:0]  sample_num_ff, exp_sample = 0, len;
	logic [543:0] rec;
	int           n_mismatch = 0, num_checks = 0, cyc = 0, s, k;
	isrf_framer isrf_framer_i (.clock, .nrst, .clk_en, .single_snapshot_request, .periodic_snapshot_request,
		.snapshot_tick, .ext_io_fitted, .error_code, .prog_running, .wait_input, .trace_on, .echo_on,
		.analog_out_counts, .analog_in_counts, .analog_input_range_select, .dig_out, .dig_in, .ext_dig_out,
		.ext_dig_in, .pulse_count, .user_variable_a, .user_variable_b, .rec_data_ff, .rec_valid_ff,
		.rec_last_ff, .rec_ready, .busy_ff, .sample_num_ff);
	isrf_host_model isrf_host_model_i (.clock, .nrst, .rec_data_ff, .rec_valid_ff, .rec_ready, .stall, .clear);
	initial forever #5 clock = !clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// a second request while busy must be dropped, so one record and one sample step per run
	task automatic run(input logic x, input logic st, input logic per);
		len = x ? 16'h0044 : 16'h003C;
		@(posedge clock); #1 ext_io_fitted = x;
		stall = st;
		clear = 1;
		clk_en = 0;
		single_snapshot_request = !per;
		periodic_snapshot_request = per;
		snapshot_tick = per;
		// the first edge sees the request while frozen, so nothing may start there
		@(posedge clock); #1 clk_en = 1;
		`CHK("frozen busy", 1'b0, busy_ff)
		`CHK("frozen sample", exp_sample, sample_num_ff)
		@(posedge clock); #1 clear = 0;
		single_snapshot_request = 0;
		snapshot_tick = 0;
		exp_sample++;
		repeat (4) @(posedge clock);
		#1 single_snapshot_request = 1;
		@(posedge clock); #1 single_snapshot_request = 0;
		for (k = 0; k < 2000 && isrf_host_model_i.n_rx < len; k++) @(posedge clock);
		repeat (8) @(posedge clock);
		rec = {8'h00, ext_dig_in, 8'h00, ext_dig_out, user_variable_b, user_variable_a, pulse_count,
			8'h00, dig_in, 8'h00, dig_out, analog_in_counts, analog_out_counts,
			prog_running, 4'h0, wait_input, trace_on, echo_on, error_code, exp_sample, len, 16'h8000};
		for (k = 0; k < len; k++) `CHK("byte", rec[8*k+:8], isrf_host_model_i.mem[k])
		`CHK("count", int'(len), isrf_host_model_i.n_rx)
		`CHK("sample", exp_sample, sample_num_ff)
		`CHK("idle", 1'b0, busy_ff)
		`CHK("idle valid", 1'b0, rec_valid_ff)
	endtask
	initial begin
		repeat (3) @(posedge clock);
		#1 nrst = 1;
		for (s = 0; s < 4; s++) begin
			@(posedge clock); #1 error_code = 8'hA5 + s[7:0];
			{prog_running, wait_input, trace_on, echo_on} = 4'h9 << s;
			analog_out_counts = {8{16'h1357}} + s;
			analog_in_counts = {{7{16'hFFFF}}, 16'h8000} - s;
			dig_out = 24'hC3A55A + s[23:0];
			dig_in = ~dig_out;
			ext_dig_out = 24'h81F00F << s;
			ext_dig_in = ~ext_dig_out;
			pulse_count = 32'h87654321 << s;
			user_variable_a = 32'h0BADF00D ^ s;
			user_variable_b = 32'hF00D0001 + s;
			run(s[0], s[1], s == 3);
		end
		summarize();
	end
endmodule
bind isrf_framer isrf_framer_monitor isrf_framer_monitor_i (.clock, .nrst, .clk_en, .single_snapshot_request,
	.periodic_snapshot_request, .snapshot_tick, .ext_io_fitted, .prog_running, .wait_input, .trace_on,
	.echo_on, .rec_data_ff, .rec_valid_ff, .rec_last_ff, .rec_ready, .busy_ff, .sample_num_ff);
`default_nettype wire
